// >>> hw/cog_pkg.sv
package cog_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 16;
  localparam int PIN_N = 7;
  // Register indices
  localparam logic [5:0] MISC_ADDR = 6'h09;
  localparam logic [5:0] CLKO_ADDR = 6'h0A;
  localparam logic [5:0] DIR_ADDR = 6'h0B;
  // misc_control_three fields
  localparam int ALT_BIT = 7;
  localparam int CLKEN_BIT = 5;
  localparam int PRESC_LSB = 0;
  localparam logic [2:0] PRESC_RST = 3'h0;
  localparam logic CLKEN_RST = 1'b1;
  // clock_output_control fields
  localparam int TRIM_LSB = 8;
  localparam int RATE_LSB = 0;
  localparam logic [7:0] TRIM_RST = 8'h7E;
  localparam logic [2:0] RATE_RST = 3'h6;
  // pin_direction_control fields
  localparam int DRV_LSB = 14;
  localparam int OEN_LSB = 7;
  localparam int IEN_LSB = 0;
  localparam logic [1:0] DRV_RST = 2'h0;
  // Reference periods per output period, one entry per rate code
  localparam int DIV_W = 10;
  localparam logic [9:0] DIV_0 = 10'h001;
  localparam logic [9:0] DIV_1 = 10'h002;
  localparam logic [9:0] DIV_2 = 10'h004;
  localparam logic [9:0] DIV_3 = 10'h008;
  localparam logic [9:0] DIV_4 = 10'h010;
  localparam logic [9:0] DIV_5 = 10'h100;
  localparam logic [9:0] DIV_6 = 10'h1E8;
  localparam logic [9:0] DIV_7 = 10'h3D0;

  typedef struct packed {
    logic [5:0] addr;
    logic [15:0] data;
    logic wrEn;
    logic rdEn;
  } cog_req_s;

  typedef struct packed {
    logic [6:0] value;
    logic [6:0] oe;
  } cog_pins_s;
endpackage : cog_pkg

// >>> hw/cog_clock_out_gpio.sv
`timescale 1ns/10ps
// How it works
// - With the alternate select set, pin 1 shows out-of-idle and pin 2 shows a valid result.
// - With the alternate select clear, pins 1 and 2 are plain pins under direction and value.
// - The clock output toggles at the chosen rate when enabled (reset state) and is low when not.
// - Rate codes 000 to 100 give 16, 8, 4, 2, 1 MHz and code 101 gives 62.5 kHz.
// - Rate code 110, the reset value, divides the reference by 488.
// - Rate code 111 divides the reference by 976.
// - The timer prescale field in bits 2 to 0 picks the event timer base clock.
// - The crystal trim byte resets to 0x7E and sets the oscillator load.
// - Pins 7 down to 1 have output enables at bits 13 down to 7.
// - Pins 7 down to 1 have input enables at bits 6 down to 0.
// - A pin with both enables set is an input and is not driven, except pins 1 and 2 while the alternate select is set.
// - Reset tristates every pin and returns all directions to input.
// - The drive field in bits 15 to 14 sets pins 1 to 4 drive, 00 weakest at reset.
module cog_clock_out_gpio #(
  parameter int PIN_N = cog_pkg::PIN_N
)(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire cog_pkg::cog_req_s req,
  output logic [15:0] regRdData,
  input wire logic refTick,
  input wire logic xcvrActive,
  input wire logic resultValid,
  input wire logic [6:0] pinOutValue,
  input wire logic [6:0] pinPadIn,
  output cog_pkg::cog_pins_s pinDrive,
  output logic [6:0] pinInData,
  output logic [1:0] lowPinsDriveStrength,
  output logic [7:0] crystalLoadTrim,
  output logic [2:0] eventTimerPrescale,
  output logic clockOut
);
  // Masks, views and status muxing are laid out for exactly seven pins
  if (PIN_N != 7)
  begin : g_pinCountCheck
    $error("cog_clock_out_gpio serves exactly seven pins");
  end

  function automatic logic [9:0] divFor(input logic [2:0] code);
    case (code)
      3'h0: divFor = cog_pkg::DIV_0;
      3'h1: divFor = cog_pkg::DIV_1;
      3'h2: divFor = cog_pkg::DIV_2;
      3'h3: divFor = cog_pkg::DIV_3;
      3'h4: divFor = cog_pkg::DIV_4;
      3'h5: divFor = cog_pkg::DIV_5;
      3'h6: divFor = cog_pkg::DIV_6;
      default: divFor = cog_pkg::DIV_7;
    endcase
  endfunction : divFor

  logic statusAlt_r;
  logic clockOutEnable_r;
  logic [2:0] prescale_r;
  logic [7:0] trim_r;
  logic [2:0] rate_r;
  logic [1:0] drive_r;
  logic [6:0] outEnable_r;
  logic [6:0] inEnable_r;
  logic [6:0] padSync1_r;
  logic [6:0] padSync2_r;
  logic [9:0] divCnt_r;
  logic clkOut_r;
  logic [6:0] pinVal_r;
  logic [6:0] pinOe_r;
  logic [6:0] pinIn_r;
  logic [15:0] rdData_r;

  wire logic wrMisc = req.wrEn && (req.addr == cog_pkg::MISC_ADDR);
  wire logic wrClko = req.wrEn && (req.addr == cog_pkg::CLKO_ADDR);
  wire logic wrDir = req.wrEn && (req.addr == cog_pkg::DIR_ADDR);

  wire logic [15:0] miscView = {8'h00, statusAlt_r, 1'b0, clockOutEnable_r, 2'h0, prescale_r};
  wire logic [15:0] clkoView = {trim_r, 5'h00, rate_r};
  wire logic [15:0] dirView = {drive_r, outEnable_r, inEnable_r};
  logic [15:0] rdSel;
  always_comb
  begin
    if (req.addr == cog_pkg::MISC_ADDR)
      rdSel = miscView;
    else if (req.addr == cog_pkg::CLKO_ADDR)
      rdSel = clkoView;
    else if (req.addr == cog_pkg::DIR_ADDR)
      rdSel = dirView;
    else
      rdSel = 16'h0000;
  end

  // Input setting wins over output setting
  wire logic [6:0] driveMask = outEnable_r & ~inEnable_r;
  wire logic [6:0] readMask = inEnable_r;
  // Alternate mode forces pins 1 and 2 to drive status regardless of direction
  wire logic [6:0] oeNxt = statusAlt_r ? {driveMask[6:2], 2'b11} : driveMask;
  wire logic [6:0] valNxt = statusAlt_r ?
    {pinOutValue[6:2], resultValid, xcvrActive} : pinOutValue;

  // Half an output period in reference ticks; refTick runs at twice the reference
  wire logic [9:0] halfCnt = divFor(rate_r);
  wire logic divWrap = (divCnt_r >= halfCnt - 10'h001);

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      statusAlt_r <= 1'b0;
      clockOutEnable_r <= cog_pkg::CLKEN_RST;
      prescale_r <= cog_pkg::PRESC_RST;
    end
    else if (ce && wrMisc)
    begin
      statusAlt_r <= req.data[cog_pkg::ALT_BIT];
      clockOutEnable_r <= req.data[cog_pkg::CLKEN_BIT];
      prescale_r <= req.data[cog_pkg::PRESC_LSB +: 3];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      trim_r <= cog_pkg::TRIM_RST;
      rate_r <= cog_pkg::RATE_RST;
    end
    else if (ce && wrClko)
    begin
      trim_r <= req.data[cog_pkg::TRIM_LSB +: 8];
      rate_r <= req.data[cog_pkg::RATE_LSB +: 3];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      drive_r <= cog_pkg::DRV_RST;
      outEnable_r <= 7'h00;
      inEnable_r <= 7'h7F;
    end
    else if (ce && wrDir)
    begin
      drive_r <= req.data[cog_pkg::DRV_LSB +: 2];
      outEnable_r <= req.data[cog_pkg::OEN_LSB +: 7];
      inEnable_r <= req.data[cog_pkg::IEN_LSB +: 7];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      padSync1_r <= 7'h00;
      padSync2_r <= 7'h00;
    end
    else if (ce)
    begin
      padSync1_r <= pinPadIn;
      padSync2_r <= padSync1_r;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      pinVal_r <= 7'h00;
      pinOe_r <= 7'h00;
      pinIn_r <= 7'h00;
      rdData_r <= 16'h0000;
    end
    else if (ce)
    begin
      pinVal_r <= valNxt;
      pinOe_r <= oeNxt;
      pinIn_r <= padSync2_r & readMask;
      if (req.rdEn)
        rdData_r <= rdSel;
    end
  end

  // Counter restarts when disabled so the first edge after enabling is a full half period
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      divCnt_r <= 10'h000;
      clkOut_r <= 1'b0;
    end
    else if (ce)
    begin
      if (!clockOutEnable_r)
      begin
        divCnt_r <= 10'h000;
        clkOut_r <= 1'b0;
      end
      else if (refTick)
      begin
        if (divWrap)
        begin
          divCnt_r <= 10'h000;
          clkOut_r <= ~clkOut_r;
        end
        else
          divCnt_r <= divCnt_r + 10'h001;
      end
    end
  end

  assign regRdData = rdData_r;
  // One assignment so the struct has a single driver
  assign pinDrive = '{value: pinVal_r, oe: pinOe_r};
  assign pinInData = pinIn_r;
  assign lowPinsDriveStrength = drive_r;
  assign crystalLoadTrim = trim_r;
  assign eventTimerPrescale = prescale_r;
  assign clockOut = clkOut_r;
endmodule : cog_clock_out_gpio

// >>> testbench/cog_host_model.sv
`timescale 1ns/10ps
module cog_host_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire cog_pkg::cog_pins_s pinDrive,
  input wire logic [6:0] hostOe,
  input wire logic [6:0] hostVal,
  input wire logic clockOut,
  output logic refTick,
  output logic [6:0] pinPadIn,
  output int period,
  output int rises
);
  int ticks;
  logic [6:0] flt;
  logic last;
  logic rise;
  assign rise = clockOut & ~last;
  // Released pads wander so a stale level never passes
  assign pinPadIn = pinDrive.oe & pinDrive.value
    | ~pinDrive.oe & (hostOe & hostVal | ~hostOe & flt);
  always @(posedge clk)
  begin
    refTick <= rst_b & ~refTick;
    flt <= rst_b ? ~flt : 7'h00;
    last <= clockOut;
    ticks <= rise ? int'(refTick) : ticks + refTick;
    if (rise)
    begin
      period <= ticks;
      rises <= rises + 1;
    end
  end
endmodule : cog_host_model

// >>> testbench/cog_clock_out_gpio_sva.sv
`timescale 1ns/10ps
module cog_gpio_chk (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire cog_pkg::cog_req_s req,
  input wire logic [15:0] regRdData,
  input wire logic refTick,
  input wire logic xcvrActive,
  input wire logic resultValid,
  input wire logic [6:0] pinOutValue,
  input wire cog_pkg::cog_pins_s pinDrive,
  input wire logic [7:0] crystalLoadTrim,
  input wire logic clockOut
);
  logic [15:0] dir_r;
  logic alt_r, en_r;
  logic [6:0] expOe;
  logic wt;
  assign wt = ce & req.wrEn;
  // Alt mode owns pins 1 and 2 whatever the direction bits say
  assign expOe = (dir_r[13:7] & ~dir_r[6:0]) | {5'h00, alt_r, alt_r};
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      {dir_r, alt_r, en_r} <= {16'h007F, 2'h1};
    else if (wt && req.addr == 6'h0B)
      dir_r <= req.data;
    else if (wt && req.addr == 6'h09)
      {alt_r, en_r} <= {req.data[7], req.data[5]};
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  a_reset_state: assert property (disable iff (1'b0)
    !rst_b |=> pinDrive.oe == 7'h00 && crystalLoadTrim == 8'h7E && !clockOut) else $error("reset");
  a_oe_map: assert property ($past({ce, rst_b}) == 2'h3 |->
    pinDrive.oe == $past(expOe)) else $error("oe");
  a_alt_status: assert property ($past(alt_r & ce & rst_b) |->
    pinDrive.value[1:0] == $past({resultValid, xcvrActive})) else $error("alt");
  a_plain_pins: assert property ($past(!alt_r && ce && rst_b && expOe[1:0] == 2'h3) |->
    pinDrive.value[1:0] == $past(pinOutValue[1:0])) else $error("plain");
  a_rd_unmapped: assert property (ce && req.rdEn && req.addr == 6'h0C |=>
    regRdData == 16'h0000) else $error("unmapped");
  a_rd_holds: assert property (!(ce && req.rdEn) |=> $stable(regRdData)) else $error("hold");
  a_clk_off: assert property (ce && !en_r |=> !clockOut) else $error("clk off");
  a_clk_idle: assert property (en_r && !refTick |=> $stable(clockOut)) else $error("idle");
  c_alt: cover property (alt_r && xcvrActive);
  c_both: cover property ((dir_r[13:7] & dir_r[6:0]) != 7'h00);
  c_tick: cover property (en_r && refTick ##1 $changed(clockOut));
endmodule : cog_gpio_chk
bind cog_clock_out_gpio cog_gpio_chk u_cog_gpio_chk (.clk, .rst_b, .ce, .req, .regRdData,
  .refTick, .xcvrActive, .resultValid, .pinOutValue, .pinDrive, .crystalLoadTrim, .clockOut);

// >>> testbench/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic clk = 1'b0, rst_b = 1'b0, ce = 1'b1, xcvrActive = 1'b1, resultValid = 1'b0;
  logic refTick, clockOut;
  logic [6:0] pinOutValue = 7'h55, hostOe = 7'h00, hostVal = 7'h5A, pinPadIn, pinInData;
  cog_pkg::cog_req_s req = '0;
  cog_pkg::cog_pins_s pinDrive;
  logic [15:0] regRdData;
  logic [1:0] lowPinsDriveStrength;
  logic [7:0] crystalLoadTrim;
  logic [2:0] eventTimerPrescale;
  int period, rises, err_total = 0, comparisons = 0, cycles = 0;
  int divs [8] = '{1, 2, 4, 8, 16, 256, 488, 976};
  cog_clock_out_gpio u_cog_clock_out_gpio (.clk, .rst_b, .ce, .req, .regRdData, .refTick,
    .xcvrActive, .resultValid, .pinOutValue, .pinPadIn, .pinDrive, .pinInData,
    .lowPinsDriveStrength, .crystalLoadTrim, .eventTimerPrescale, .clockOut);
  cog_host_model u_cog_host_model (.clk, .rst_b, .pinDrive, .hostOe, .hostVal, .clockOut,
    .refTick, .pinPadIn, .period, .rises);
  initial forever #25 clk = ~clk;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    req.wrEn <= 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [15:0] e);
    @(posedge clk);
    req <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk);
    req.rdEn <= 1'b0;
    @(posedge clk);
    chk(regRdData, e);
  endtask : rd
  task automatic tally_and_finish;
    $display("compares %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      err_total++;
      tally_and_finish;
    end
  end
  initial
  begin
    int r0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    rd(6'h09, 16'h0020);
    rd(6'h0A, 16'h7E06);
    rd(6'h0B, 16'h007F);
    rd(6'h0C, 16'h0000);
    // Three rises so a rate change mid-period is not measured
    for (int c = 0; c < 8; c++)
    begin
      wr(6'h0A, {13'h0FC0, 3'(c)});
      r0 = rises;
      for (int n = 0; n < 13000 && rises < r0 + 3; n++) @(posedge clk);
      chk(16'(period), 16'(2 * divs[c]));
    end
    wr(6'h09, 16'h0085);
    repeat (3) @(posedge clk);
    chk(16'(clockOut), 16'h0000);
    chk(16'(eventTimerPrescale), 16'h0005);
    chk(16'({pinDrive.oe, pinDrive.value[1:0]}), 16'h000D);
    xcvrActive <= 1'b0;
    resultValid <= 1'b1;
    repeat (2) @(posedge clk);
    chk(16'(pinDrive.value[1:0]), 16'h0002);
    wr(6'h0B, 16'hFFFC);
    wr(6'h09, 16'h0020);
    repeat (3) @(posedge clk);
    chk(16'({pinDrive.oe, pinDrive.value[1:0]}), 16'h000D);
    chk(16'(lowPinsDriveStrength), 16'h0003);
    wr(6'h0B, 16'h000F);
    hostOe <= 7'h7F;
    wr(6'h0A, 16'h3306);
    repeat (5) @(posedge clk);
    chk(16'(pinInData), 16'h000A);
    chk(16'(crystalLoadTrim), 16'h0033);
    // A write with the enable low must leave the trim untouched
    ce <= 1'b0;
    wr(6'h0A, 16'h1206);
    ce <= 1'b1;
    rd(6'h0A, 16'h3306);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    chk(16'(pinDrive.oe), 16'h0000);
    rd(6'h0B, 16'h007F);
    tally_and_finish;
  end
endmodule : testbench
